// ==== rtl/dcf_pkg.sv ====
// dcf_pkg: offsets, field positions, reset values for the device control block
// assumes a 32-bit apb register bus, one aligned word per register
package dcf_pkg;
  localparam logic [11:0] DCF_DEV_CTRL_OFS  = 12'h070;
  localparam logic [11:0] DCF_ERR_EVT_OFS   = 12'h100;
  localparam logic [11:0] DCF_IRQ_MASK_OFS  = 12'h104;
  localparam logic [11:0] DCF_DEV_CAP_OFS   = 12'h06c;
  localparam int DCF_COR_BIT  = 0;
  localparam int DCF_NF_BIT   = 1;
  localparam int DCF_FAT_BIT  = 2;
  localparam int DCF_UR_BIT   = 3;
  localparam int DCF_RO_BIT   = 4;
  localparam int DCF_MPS_LSB  = 5;
  localparam int DCF_DET_LSB  = 16;
  localparam int DCF_NUM_CLS  = 4;
  localparam logic [3:0]  DCF_EN_RST   = 4'h0;
  localparam logic [2:0]  DCF_MPS_RST  = 3'h0;
  localparam logic [2:0]  DCF_MPS_128  = 3'h0;
  localparam logic [2:0]  DCF_MPS_256  = 3'h1;
  localparam logic [2:0]  DCF_MPS_SUPP = 3'h1;
  localparam logic [3:0]  DCF_DET_RST  = 4'h0;
  localparam logic [3:0]  DCF_MASK_RST = 4'h0;
  localparam logic [12:0] DCF_LEN_128  = 13'h0080;
  localparam logic [12:0] DCF_LEN_256  = 13'h0100;
endpackage

// ==== rtl/dcf_evt_bits.sv ====
// dcf_evt_bits: sticky per-class event flags with clear; set wins over clear
// assumes events and clears come from pclk logic
`timescale 1ns/1ns
`default_nettype none
module dcf_evt_bits #(
  parameter int N = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  output logic      [N-1:0] flag_q
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_q[g] <= 1'b0;
        end else if (set_i[g]) begin
          flag_q[g] <= 1'b1;
        end else if (clr_i[g]) begin
          flag_q[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // dcf_evt_bits
`default_nettype wire

// ==== rtl/dcf_dev_ctrl.sv ====
// dcf_dev_ctrl: device control/status word, error reporting gates, payload limit
// assumes error events are one-cycle pulses on pclk from the detection logic
`timescale 1ns/1ns
`default_nettype none
module dcf_dev_ctrl
  import dcf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  err_evt,
  output logic      [3:0]  err_report,
  output logic      [2:0]  mps_sel,
  output logic      [12:0] mps_bytes,
  input  wire logic [12:0] tx_len,
  output logic             tx_len_ok,
  output logic             irq
);
  // register, event and report state
  logic [3:0]  en_q;
  logic [3:0]  en_d;
  logic [2:0]  mps_q;
  logic [2:0]  mps_d;
  logic [12:0] mps_bytes_q;
  logic [12:0] mps_bytes_d;
  logic [3:0]  mask_q;
  logic [3:0]  mask_d;
  logic [3:0]  det_q;
  logic [3:0]  evt_q;
  logic [3:0]  pend;
  logic [3:0]  report_q;
  logic [31:0] rdata_q;

  // bus decode
  logic        acc;
  logic        setup_rd;
  logic        wr;
  logic        rd;
  logic        hit_ctrl;
  logic        hit_evt;
  logic        hit_mask;
  logic        hit_cap;
  logic        hit_any;
  logic        wr_ctrl_lo;
  logic        wr_ctrl_st;
  logic        wr_mask;
  logic        rd_evt;
  logic        mps_legal;

  // side effects and read words
  logic [3:0]  det_clr;
  logic [3:0]  evt_clr;
  logic [31:0] ctrl_word;
  logic [31:0] evt_word;
  logic [31:0] mask_word;
  logic [31:0] cap_word;
  logic [31:0] rd_mux;

  assign acc        = psel && penable;
  assign setup_rd   = psel && !penable && !pwrite;
  assign wr         = acc && pwrite;
  assign rd         = acc && !pwrite;
  assign hit_ctrl   = (paddr == DCF_DEV_CTRL_OFS);
  assign hit_evt    = (paddr == DCF_ERR_EVT_OFS);
  assign hit_mask   = (paddr == DCF_IRQ_MASK_OFS);
  assign hit_cap    = (paddr == DCF_DEV_CAP_OFS);
  assign hit_any    = hit_ctrl || hit_evt || hit_mask || hit_cap;
  assign wr_ctrl_lo = wr && hit_ctrl && pstrb[0];
  assign wr_ctrl_st = wr && hit_ctrl && pstrb[2];
  assign wr_mask    = wr && hit_mask && pstrb[0];
  assign rd_evt     = rd && hit_evt;
  assign pready     = 1'b1;
  assign pslverr    = acc && !hit_any;

  // an unsupported size code leaves the field as it was
  assign mps_legal = (pwdata[DCF_MPS_LSB+2:DCF_MPS_LSB] <= DCF_MPS_SUPP);

  always_comb begin
    en_d        = en_q;
    mps_d       = mps_q;
    mps_bytes_d = mps_bytes_q;
    if (wr_ctrl_lo) begin
      en_d = pwdata[DCF_UR_BIT:DCF_COR_BIT];
      if (mps_legal) begin
        mps_d       = pwdata[DCF_MPS_LSB+2:DCF_MPS_LSB];
        mps_bytes_d = (pwdata[DCF_MPS_LSB+2:DCF_MPS_LSB] == DCF_MPS_256) ? DCF_LEN_256 : DCF_LEN_128;
      end
    end
  end

  // reporting enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= DCF_EN_RST;
    end else begin
      en_q <= en_d;
    end
  end

  // payload size code and its byte count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mps_q       <= DCF_MPS_RST;
      mps_bytes_q <= DCF_LEN_128;
    end else begin
      mps_q       <= mps_d;
      mps_bytes_q <= mps_bytes_d;
    end
  end

  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = pwdata[DCF_NUM_CLS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= DCF_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // detected flags: write-one-to-clear on byte lane 2
  always_comb begin
    det_clr = 4'h0;
    if (wr_ctrl_st) begin
      det_clr = pwdata[DCF_DET_LSB+3:DCF_DET_LSB];
    end
  end

  // a status read clears only what its setup cycle captured,
  // so an event landing between setup and access is kept
  always_comb begin
    evt_clr = 4'h0;
    if (rd_evt) begin
      evt_clr = rdata_q[DCF_NUM_CLS-1:0];
    end
  end

  dcf_evt_bits #(.N(DCF_NUM_CLS)) u_det (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (err_evt),
    .clr_i   (det_clr),
    .flag_q  (det_q)
  );

  // event status: sticky, cleared by a status read
  dcf_evt_bits #(.N(DCF_NUM_CLS)) u_evt (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (err_evt),
    .clr_i   (evt_clr),
    .flag_q  (evt_q)
  );

  // reporting pulses gated by enables, one lane per error class
  genvar c;
  generate
    for (c = 0; c < DCF_NUM_CLS; c++) begin : g_rpt
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          report_q[c] <= 1'b0;
        end else begin
          report_q[c] <= err_evt[c] && en_q[c];
        end
      end
    end
  endgenerate

  // read words, one per register
  always_comb begin
    ctrl_word                            = 32'h0000_0000;
    ctrl_word[DCF_UR_BIT:DCF_COR_BIT]    = en_q;
    ctrl_word[DCF_RO_BIT]                = 1'b0;
    ctrl_word[DCF_MPS_LSB+2:DCF_MPS_LSB] = mps_q;
    ctrl_word[11:8]                      = 4'h0;
    ctrl_word[DCF_DET_LSB+3:DCF_DET_LSB] = det_q;
  end

  always_comb begin
    evt_word                  = 32'h0000_0000;
    evt_word[DCF_NUM_CLS-1:0] = evt_q;
  end

  always_comb begin
    mask_word                  = 32'h0000_0000;
    mask_word[DCF_NUM_CLS-1:0] = mask_q;
  end

  always_comb begin
    cap_word      = 32'h0000_0000;
    cap_word[2:0] = DCF_MPS_SUPP;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux = ctrl_word;
    end else if (hit_evt) begin
      rd_mux = evt_word;
    end else if (hit_mask) begin
      rd_mux = mask_word;
    end else if (hit_cap) begin
      rd_mux = cap_word;
    end
  end

  // read data is captured in the setup cycle and stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup_rd) begin
      rdata_q <= rd_mux;
    end
  end
  assign prdata = rdata_q;

  // payload limit check against the selected size
  always_comb begin
    tx_len_ok = 1'b0;
    if (tx_len <= mps_bytes_q) begin
      tx_len_ok = 1'b1;
    end
  end

  assign err_report = report_q;
  assign mps_sel    = mps_q;
  assign mps_bytes  = mps_bytes_q;
  assign pend       = evt_q & mask_q;
  assign irq        = |pend;
endmodule // dcf_dev_ctrl
`default_nettype wire

// ==== tb/dcf_dev_ctrl_chk.sv ====
// dcf_dev_ctrl_chk: port-level assertions for dcf_dev_ctrl
// assumes bind into every dcf_dev_ctrl instance, one pclk domain
`timescale 1ns/1ns
`default_nettype none
module dcf_dev_ctrl_chk (
  input wire logic        pclk, presetn, psel, penable, pwrite, tx_len_ok,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  err_evt, err_report,
  input wire logic [2:0]  mps_sel,
  input wire logic [12:0] mps_bytes, tx_len
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd70 = psel && penable && !pwrite && paddr == 12'h070;
  wire wr70 = psel && penable && pwrite && paddr == 12'h070;
  AST_RPT: assert property (|err_report |-> (err_report & ~$past(err_evt)) == 4'h0)
    else $error("report without event");
  AST_QUIET: assert property (err_evt == 4'h0 |=> err_report == 4'h0)
    else $error("report while idle");
  AST_LEN: assert property (tx_len_ok == (tx_len <= mps_bytes))
    else $error("length limit wrong");
  AST_SIZE: assert property (mps_bytes == (mps_sel == 3'h0 ? 13'h0080 : 13'h0100))
    else $error("payload bytes wrong");
  AST_CODE: assert property (mps_sel <= 3'h1)
    else $error("unsupported size code");
  AST_HOLD: assert property (!wr70 |=> $stable(mps_sel))
    else $error("size changed without write");
  AST_RO: assert property (rd70 |-> prdata[11:8] == 4'h0 && !prdata[4])
    else $error("fixed bits not zero");
  AST_RDMPS: assert property (rd70 |-> prdata[7:5] == mps_sel)
    else $error("size readback wrong");
  cover property (rd70);
  cover property (|err_report);
  cover property (mps_sel == 3'h1);
endmodule // dcf_dev_ctrl_chk
bind dcf_dev_ctrl dcf_dev_ctrl_chk i_chk (.*);
`default_nettype wire

// ==== tb/dcf_dev_ctrl_test.sv ====
// dcf_dev_ctrl_test: apb bench, read data checked from a queue of notes
// assumes dcf_pkg and dcf_dev_ctrl compiled first
`timescale 1ns/1ns
`default_nettype none
module dcf_dev_ctrl_test import dcf_pkg::*;;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, tx_len_ok, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, lf = 32'h6e61, exp_q[$];
  logic [3:0]  pstrb = 0, err_evt = 0, err_report, en = 0, det = 0, st = 0;
  logic [2:0]  mps_sel;
  logic [12:0] mps_bytes, tx_len = 0;
  int          n_errors = 0, checks_done = 0;
  dcf_dev_ctrl i_dcf_dev_ctrl (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pstrb      (pstrb),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .err_evt    (err_evt),
    .err_report (err_report),
    .mps_sel    (mps_sel),
    .mps_bytes  (mps_bytes),
    .tx_len     (tx_len),
    .tx_len_ok  (tx_len_ok),
    .irq        (irq)
  );
  always #50 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task apb(input [11:0] a, input w, input [31:0] d, input [3:0] s);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    {psel, penable} <= 2'b00;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    exp_q.push_back(e);
    apb(a, 0, 0, 0);
  endtask
  task ev(input [3:0] v);
    @(posedge pclk) err_evt <= v;
    @(posedge pclk) err_evt <= 0;
    @(negedge pclk) chk(err_report, v & en);
    det |= v;
    st |= v;
    @(negedge pclk);
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) chk(prdata, exp_q.pop_front());
  always @(posedge pclk)
    if (psel && penable && pready) chk(pslverr, paddr == 12'h200);
  initial begin
    #1000000 n_errors++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rd(DCF_DEV_CTRL_OFS, 0);
    rd(DCF_DEV_CAP_OFS, 1);
    chk(mps_bytes, DCF_LEN_128);
    apb(DCF_DEV_CTRL_OFS, 1, 32'hffff_ff1f, 4'h1);
    en = 4'hf;
    rd(DCF_DEV_CTRL_OFS, 32'h0000_000f);
    apb(DCF_DEV_CTRL_OFS, 1, 32'h0000_0021, 4'h0);
    rd(DCF_DEV_CTRL_OFS, 32'h0000_000f);
    apb(DCF_DEV_CTRL_OFS, 1, 32'h0000_0021, 4'h1);
    en = 4'h1;
    tx_len <= 13'h0101;
    rd(DCF_DEV_CTRL_OFS, 32'h0000_0021);
    chk(tx_len_ok, 0);
    chk(mps_bytes, DCF_LEN_256);
    tx_len <= 13'h0100;
    @(negedge pclk) chk(tx_len_ok, 1);
    $display("field test done");
    apb(DCF_IRQ_MASK_OFS, 1, 32'h0000_000f, 4'h1);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      en = lf[3:0];
      apb(DCF_DEV_CTRL_OFS, 1, {lf[31:8], 3'h1, lf[4:0]}, 4'h1);
      ev((4'h1 << i[1:0]) | lf[11:8]);
      chk(irq, 1);
      rd(DCF_ERR_EVT_OFS, st);
      st = 0;
      repeat (2) @(negedge pclk);
      chk(irq, 0);
    end
    rd(DCF_DEV_CTRL_OFS, {12'h0, det, 16'h0020} | en);
    apb(DCF_DEV_CTRL_OFS, 1, 32'h000f_0000, 4'h4);
    rd(DCF_DEV_CTRL_OFS, 32'h0000_0020 | en);
    apb(DCF_IRQ_MASK_OFS, 1, 0, 4'h1);
    ev(4'h1);
    chk(irq, 0);
    rd(DCF_ERR_EVT_OFS, 1);
    rd(12'h200, 0);
    $display("event test done");
    wrap_up;
  end
endmodule // dcf_dev_ctrl_test
`default_nettype wire
